// ### tcp_pkg.sv
// Package of constants and types for the two-channel PWM block
// ========================================
// How it works
// - Start-level one: high first, low at duty
// - Start-level zero: low first, high at duty
// - Start-level bits writable any time
// - Clock-source selects writable any time
// - Alignment bit one centers, zero left-aligns
// - Clock A is link clock over 2^code
// - Clock B is link clock over 2^code
// - Prescale fields writable any time
// - Scaled A is clock A over 2*scale
// - Scaled B is clock B over 2*scale
// - Scale zero means 256, divide 512
// - Scale write reloads its down-counter now
// - Per-channel 8-bit counter at selected rate
// - Counter read leaves count undisturbed
// - Left mode counts 0 to period-1
// - Center mode counts up to period, down
// - Counter write clears, up, loads, sets output
// - Counter cleared at end of period
// - Disabled counter holds, resumes on enable
// - Prescale, scale, counters reset to zero
// - Channel clock: base or scaled by select
// - Enable takes effect at next source tick
// - Both disabled stops the prescale counter
// - Duty equals counter toggles the output
package tcp_pkg;
  // ========================================
  // Register offsets (word indices; byte address is four times the offset)
  localparam logic [7:0] OFF_CONTROL = 8'h60;
  localparam logic [7:0] OFF_PRESCALE = 8'h61;
  localparam logic [7:0] OFF_SCALE_A = 8'h62;
  localparam logic [7:0] OFF_SCALE_B = 8'h63;
  localparam logic [7:0] OFF_COUNT0 = 8'h64;
  localparam logic [7:0] OFF_COUNT1 = 8'h65;
  localparam logic [7:0] OFF_PERIOD0 = 8'h66;
  localparam logic [7:0] OFF_PERIOD1 = 8'h67;
  localparam logic [7:0] OFF_DUTY0 = 8'h68;
  localparam logic [7:0] OFF_DUTY1 = 8'h69;
  // ========================================
  // Field positions and reset values
  localparam int CTL_ENABLE_LSB = 0;
  localparam int CTL_LEVEL_LSB = 2;
  localparam int CTL_CLKSEL_LSB = 4;
  localparam int CTL_CENTER_LSB = 6;
  localparam int PRE_A_LSB = 0;
  localparam int PRE_B_LSB = 4;
  localparam logic [7:0] PRESCALE_MASK = 8'h77;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [8:0] SCALE_FULL = 9'h100;
  localparam int PRESCALE_BITS = 7;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] duty;
  } tcp_wave_s;
endpackage

// ### tcp_pwm.sv
// Two-channel 8-bit PWM with prescalers, scalers and APB registers
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
module tcp_pwm #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Waveform outputs
  output logic [CHANNELS-1:0] PWM_OUT
);
  if (CHANNELS != 2) begin : g_bad_channels
    $error("tcp_pwm serves exactly two channels");
  end

  // ========================================
  // Bus decode
  wire setup = PSEL && !PENABLE;
  wire wr = setup && PWRITE;
  wire [7:0] wbyte = PWDATA[7:0];
  wire word_ok = PADDR[1:0] == 2'b00;

  // Byte address decode: each register is one 32-bit aligned word
  function automatic logic hit(input logic [11:0] a, input logic [7:0] off);
    hit = (a[11:2] == {2'b00, off}) && (a[1:0] == 2'b00);
  endfunction
  function automatic logic [7:0] to_off(input logic [11:0] a);
    to_off = a[9:2];
  endfunction

  // Registers sit at word index = printed offset
  wire w_ctl = wr && hit(PADDR, tcp_pkg::OFF_CONTROL);
  wire w_pre = wr && hit(PADDR, tcp_pkg::OFF_PRESCALE);
  wire w_sa = wr && hit(PADDR, tcp_pkg::OFF_SCALE_A);
  wire w_sb = wr && hit(PADDR, tcp_pkg::OFF_SCALE_B);
  wire [1:0] w_cnt = {wr && hit(PADDR, tcp_pkg::OFF_COUNT1),
                      wr && hit(PADDR, tcp_pkg::OFF_COUNT0)};
  wire [1:0] w_per = {wr && hit(PADDR, tcp_pkg::OFF_PERIOD1),
                      wr && hit(PADDR, tcp_pkg::OFF_PERIOD0)};
  wire [1:0] w_dty = {wr && hit(PADDR, tcp_pkg::OFF_DUTY1),
                      wr && hit(PADDR, tcp_pkg::OFF_DUTY0)};
  wire mapped = PADDR[11:10] == 2'b00 && word_ok
                && to_off(PADDR) >= tcp_pkg::OFF_CONTROL
                && to_off(PADDR) <= tcp_pkg::OFF_DUTY1;

  // ========================================
  // Software-visible registers
  logic [7:0] control;
  logic [7:0] prescale_select;
  logic [7:0] scale_a_value;
  logic [7:0] scale_b_value;
  tcp_pkg::tcp_wave_s buffer [2];

  wire [1:0] channel_enable_bit = control[tcp_pkg::CTL_ENABLE_LSB +: 2];
  wire [1:0] start_level_bit = control[tcp_pkg::CTL_LEVEL_LSB +: 2];
  wire [1:0] clock_source_sel = control[tcp_pkg::CTL_CLKSEL_LSB +: 2];
  wire [1:0] center_align_sel = control[tcp_pkg::CTL_CENTER_LSB +: 2];
  wire [2:0] clock_a_divider_sel = prescale_select[tcp_pkg::PRE_A_LSB +: 3];
  wire [2:0] clock_b_divider_sel = prescale_select[tcp_pkg::PRE_B_LSB +: 3];

  // Next register values from the setup cycle write
  logic [7:0] next_control;
  logic [7:0] next_prescale;
  logic [7:0] next_scale_a;
  logic [7:0] next_scale_b;
  always_comb begin
    next_control = control;
    next_prescale = prescale_select;
    next_scale_a = scale_a_value;
    next_scale_b = scale_b_value;
    if (w_ctl) begin
      next_control = wbyte;
    end
    if (w_pre) begin
      next_prescale = wbyte & tcp_pkg::PRESCALE_MASK;
    end
    if (w_sa) begin
      next_scale_a = wbyte;
    end
    if (w_sb) begin
      next_scale_b = wbyte;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      control <= tcp_pkg::RESET_BYTE;
      prescale_select <= tcp_pkg::RESET_BYTE;
      scale_a_value <= tcp_pkg::RESET_BYTE;
      scale_b_value <= tcp_pkg::RESET_BYTE;
    end else begin
      control <= next_control;
      prescale_select <= next_prescale;
      scale_a_value <= next_scale_a;
      scale_b_value <= next_scale_b;
    end
  end

  // ========================================
  // Prescaler: free counter, halted when both channels are off
  logic [tcp_pkg::PRESCALE_BITS-1:0] prescale_count;
  wire any_enabled = |channel_enable_bit;
  // Holding the count at zero and gating ticks with any_enabled keeps clocks A and B still
  logic [tcp_pkg::PRESCALE_BITS-1:0] next_prescale_count;
  assign next_prescale_count = any_enabled ? prescale_count + 1'b1
                                           : '0;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      prescale_count <= '0;
    end else begin
      prescale_count <= next_prescale_count;
    end
  end

  // Tick when the low code bits of the count are all ones
  function automatic logic div_tick(input logic [6:0] cnt,
                                    input logic [2:0] code);
    logic [6:0] mask;
    mask = 7'(({7'h00, 1'b1} << code) - 8'h01);
    div_tick = (cnt & mask) == mask;
  endfunction

  wire [1:0] base_tick;
  assign base_tick[0] = any_enabled
                        && div_tick(prescale_count, clock_a_divider_sel);
  assign base_tick[1] = any_enabled
                        && div_tick(prescale_count, clock_b_divider_sel);

  // ========================================
  // Scalers: down-counter from scale value, then divide by two
  logic [8:0] scale_count [2];
  logic [1:0] scale_half;
  wire [1:0] scale_write = {w_sb, w_sa};
  wire [7:0] scale_value [2];
  assign scale_value[0] = scale_a_value;
  assign scale_value[1] = scale_b_value;
  wire [1:0] scaled_tick;

  // Zero scale stands for the full scale of 256
  function automatic logic [8:0] scale_load(input logic [7:0] v);
    scale_load = (v == 8'h00) ? tcp_pkg::SCALE_FULL : {1'b0, v};
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_scale
      wire [8:0] load = scale_load(scale_value[g]);
      wire [8:0] wload = scale_load(wbyte);
      wire reach = base_tick[g] && scale_count[g] <= 9'h001;
      // Scaled tick is every second reload: 2 * scale base ticks
      assign scaled_tick[g] = reach && scale_half[g];
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          scale_count[g] <= 9'h000;
          scale_half[g] <= 1'b0;
        end else if (scale_write[g]) begin
          scale_count[g] <= wload;
          scale_half[g] <= 1'b0;
        end else if (reach) begin
          scale_count[g] <= load;
          scale_half[g] <= !scale_half[g];
        end else if (base_tick[g]) begin
          scale_count[g] <= scale_count[g] - 9'h001;
        end
      end
    end
  endgenerate

  // ========================================
  // Channels
  // Channel phase, Gray coded along off, sync, up, down
  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_SYNC = 2'b01,
    CH_UP = 2'b11,
    CH_DOWN = 2'b10
  } tcp_chan_e;

  logic [7:0] count [2];
  tcp_pkg::tcp_wave_s active [2];
  tcp_chan_e state [2];
  logic [1:0] level;

  generate
    for (g = 0; g < 2; g++) begin : g_chan
      tcp_pkg::tcp_wave_s next_buffer;
      tcp_chan_e next_state;
      logic [7:0] next_count;
      logic next_level;
      logic next_out;
      wire tick = clock_source_sel[g] ? scaled_tick[g] : base_tick[g];
      wire counting = state[g] == CH_UP || state[g] == CH_DOWN;
      wire go = counting && tick;
      wire [7:0] per = active[g].period;
      wire center = center_align_sel[g];
      wire down = state[g] == CH_DOWN;
      wire left_end = !center && (count[g] + 8'h01 >= per);
      wire top = center && !down && count[g] >= per;
      wire bottom = center && down && count[g] <= 8'h01;
      wire ends = left_end || bottom;
      // Compare with the value being entered, so duty counts whole ticks
      wire [7:0] stepped = (top || down) ? count[g] - 8'h01
                                         : count[g] + 8'h01;
      wire match = active[g].duty == stepped;
      // Buffers reach the active copy only at safe points
      wire reload = w_cnt[g] || !channel_enable_bit[g] || (go && ends);

      // Period and duty buffers, written any time
      always_comb begin
        next_buffer = buffer[g];
        if (w_per[g]) begin
          next_buffer.period = wbyte;
        end
        if (w_dty[g]) begin
          next_buffer.duty = wbyte;
        end
      end

      // Phase and counter step
      always_comb begin
        next_state = state[g];
        next_count = count[g];
        next_level = level[g];
        if (w_cnt[g]) begin
          next_count = 8'h00;
          next_level = start_level_bit[g];
          next_state = counting ? CH_UP : state[g];
        end else if (!channel_enable_bit[g]) begin
          next_state = CH_OFF;
          next_level = start_level_bit[g];
        end else begin
          case (state[g])
            CH_OFF: next_state = CH_SYNC;
            CH_SYNC: next_state = tick ? CH_UP : CH_SYNC;
            CH_UP: next_state = (go && top) ? CH_DOWN : CH_UP;
            CH_DOWN: next_state = CH_DOWN;
            default: next_state = CH_OFF;
          endcase
          if (go && ends) begin
            next_count = 8'h00;
            next_level = start_level_bit[g];
            next_state = CH_UP;
          end else if (go) begin
            next_count = stepped;
            if (match) begin
              next_level = !level[g];
            end
          end
        end
      end

      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          buffer[g] <= '0;
        end else begin
          buffer[g] <= next_buffer;
        end
      end

      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          count[g] <= 8'h00;
          state[g] <= CH_OFF;
          active[g] <= '0;
          level[g] <= 1'b0;
        end else begin
          count[g] <= next_count;
          state[g] <= next_state;
          level[g] <= next_level;
          if (reload) begin
            active[g] <= buffer[g];
          end
        end
      end

      // Start level shows until counting begins
      assign next_out = counting ? level[g] : start_level_bit[g];
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          PWM_OUT[g] <= 1'b0;
        end else begin
          PWM_OUT[g] <= next_out;
        end
      end
    end
  endgenerate

  // ========================================
  // Read path: registered, no wait states
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    case (to_off(PADDR))
      tcp_pkg::OFF_CONTROL: rd = control;
      tcp_pkg::OFF_PRESCALE: rd = prescale_select;
      tcp_pkg::OFF_SCALE_A: rd = scale_a_value;
      tcp_pkg::OFF_SCALE_B: rd = scale_b_value;
      tcp_pkg::OFF_COUNT0: rd = count[0];
      tcp_pkg::OFF_COUNT1: rd = count[1];
      tcp_pkg::OFF_PERIOD0: rd = buffer[0].period;
      tcp_pkg::OFF_PERIOD1: rd = buffer[1].period;
      tcp_pkg::OFF_DUTY0: rd = buffer[0].duty;
      tcp_pkg::OFF_DUTY1: rd = buffer[1].duty;
      default: rd = 8'h00;
    endcase
  end

  // Data captured in setup, shown during access
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = PRDATA;
    if (setup) begin
      next_prdata = (PWRITE || !mapped) ? 32'h00000000 : {24'h000000, rd};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      PRDATA <= next_prdata;
    end
  end
endmodule

// ### tcp_pwm_assertions.sv
// Checker of bus handshake and output rules of the PWM block
`timescale 1ns/1ns
module tcp_pwm_chk #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Waveforms
  input wire logic [CHANNELS-1:0] PWM_OUT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ========================================
  // Bus phases
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence misaligned_s;
    setup_s ##0 (PADDR[1:0] != 2'h0);
  endsequence
  ready_after_setup_a: assert property (setup_s |=> PREADY)
    else $error("ready missing after setup");
  ready_one_cycle_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access phase");
  error_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  misaligned_error_a: assert property (misaligned_s |=> PSLVERR)
    else $error("misaligned access not refused");
  refused_read_zero_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read not zero");
  upper_bits_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  prescale_reserved_a: assert property (
    PREADY && !PWRITE && PADDR == 12'h184
    |-> PRDATA[7] == 1'b0 && PRDATA[3] == 1'b0)
    else $error("prescale reserved bit set");
  reset_output_low_a: assert property ($rose(RST_N) |-> PWM_OUT == '0)
    else $error("output not low after reset");
endmodule

bind tcp_pwm tcp_pwm_chk #(.CHANNELS(CHANNELS)) tcp_pwm_chk_inst (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT));

// ### tcp_load_model.sv
// Model of a load driver measuring one channel waveform
`timescale 1ns/1ns
module tcp_load_model (
  // Clock
  input wire logic clk,
  // Channel level
  input wire logic level,
  // Last period and high time in clock cycles
  output int per,
  output int hi
);
  int cnt = 0;
  int hcnt = 0;
  logic prev = 1'b0;
  // Latch counts at each rising level
  always @(posedge clk) begin
    prev <= level;
    if (level && !prev) begin
      per <= cnt;
      hi <= hcnt;
      cnt <= 1;
      hcnt <= 1;
    end else begin
      cnt <= cnt + 1;
      hcnt <= hcnt + int'(level);
    end
  end
endmodule

// ### tb_top.sv
// Testbench of the two-channel PWM block
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] pwm_out;
  logic err_seen;
  logic [31:0] r;
  int per[2];
  int hi[2];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] ctl_t[7] = '{8'h05, 8'h01, 8'h45, 8'h0A, 8'h15, 8'h2A, 8'h05};
  logic [7:0] pre_t[7] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h03};
  logic [7:0] scl_t[7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h00, 8'h01};
  int div_t[7] = '{1, 1, 1, 2, 4, 512, 8};

  always #25 clk = ~clk;

  tcp_pwm tcp_pwm_inst (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PWM_OUT(pwm_out));
  tcp_load_model tcp_load_model_inst0 (.clk(clk), .level(pwm_out[0]),
    .per(per[0]), .hi(hi[0]));
  tcp_load_model tcp_load_model_inst1 (.clk(clk), .level(pwm_out[1]),
    .per(per[1]), .hi(hi[1]));

  // ========================================
  // Bus and check tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %0h not %0h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task finish_test;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ========================================
  // Tests
  initial begin
    int ch;
    int c;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 1; i < 6; i++) begin
      apb(1'b0, 12'h180 + 12'(4 * i), 8'h00);
      check(r, 32'h0);
    end
    $display("test reset done");
    apb(1'b1, 12'h184, 8'hFF);
    apb(1'b0, 12'h184, 8'h00);
    check(r, 32'h77);
    check(err_seen, 1'b0);
    apb(1'b1, 12'h188, 8'hA5);
    apb(1'b0, 12'h188, 8'h00);
    check(r, 32'hA5);
    apb(1'b1, 12'h18C, 8'h3C);
    apb(1'b0, 12'h18C, 8'h00);
    check(r, 32'h3C);
    apb(1'b0, 12'h181, 8'h00);
    check(err_seen, 1'b1);
    apb(1'b0, 12'h1A8, 8'h00);
    check(err_seen, 1'b1);
    check(r, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 12'h180, 8'h00);
      apb(1'b1, 12'h184, pre_t[i]);
      apb(1'b1, 12'h188, scl_t[i]);
      apb(1'b1, 12'h18C, scl_t[i]);
      for (int k = 0; k < 2; k++) begin
        apb(1'b1, 12'h198 + 12'(4 * k), 8'd10);
        apb(1'b1, 12'h1A0 + 12'(4 * k), 8'd4);
        apb(1'b1, 12'h190 + 12'(4 * k), 8'h5A);
      end
      apb(1'b1, 12'h180, ctl_t[i]);
      repeat (60 * div_t[i]) @(posedge clk);
      ch = int'(ctl_t[i][1]);
      c = (ctl_t[i][6] | ctl_t[i][7]) ? 2 : 1;
      check(per[ch], 10 * div_t[i] * c);
      check(hi[ch], (ctl_t[i][2] | ctl_t[i][3] ? 4 : 6) * div_t[i] * c);
      $display("test case %0d done", i);
    end
    for (int j = 0; j < 12; j++) begin
      apb(1'b0, 12'h190, 8'h00);
      check(r < 32'd10, 1'b1);
    end
    apb(1'b1, 12'h180, 8'h00);
    apb(1'b1, 12'h190, 8'hFF);
    apb(1'b0, 12'h190, 8'h00);
    check(r, 32'h0);
    repeat (20) @(posedge clk);
    apb(1'b0, 12'h190, 8'h00);
    check(r, 32'h0);
    $display("test counter done");
    finish_test();
  end
endmodule
